// ===== bench/dma_host_model.sv
// dma controller model answering the port dma request
// assumes request pins settle on core_clk
`timescale 1ns/1ps
`default_nettype none
module dma_host_model #(parameter int tc_after = 3) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // dma pins
  input wire logic port_dma_request_o,
  input wire logic port_dma_request_oe,
  input wire logic [1:0] gap,
  output logic port_dma_acknowledge,
  output logic term_count
);
  logic [1:0] wait_cnt;
  int n;
  wire logic req;
  wire logic fire;
  // a tri-stated request line never counts as a request
  assign req = port_dma_request_o & port_dma_request_oe;
  assign fire = req & !port_dma_acknowledge & (wait_cnt >= gap);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 2'h0;
      n <= 0;
      port_dma_acknowledge <= 1'b0;
      term_count <= 1'b0;
    end else begin
      wait_cnt <= (fire || !req) ? 2'h0 : wait_cnt + 2'h1;
      port_dma_acknowledge <= fire;
      term_count <= fire && n == tc_after - 1;
      if (fire) n <= n + 1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/ecr_ctrl_chk.sv
// assertions on the extended control block, top ports only
// assumes one clock domain with rst_b as its reset
`timescale 1ns/1ps
`default_nettype none
module ecr_ctrl_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // status and pins
  input wire logic ack_pulse_irq_on,
  input wire logic [4:0] fifo_count,
  input wire logic fifo_overrun,
  input wire logic fifo_reset,
  input wire logic [2:0] port_mode,
  input wire logic port_dma_request_oe,
  input wire logic fault_b,
  input wire logic irq_o,
  input wire logic irq_oe
);
  import ecr_ctrl_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  property p_irq_oe;
    irq_oe == (ack_pulse_irq_on || port_mode inside {3'h2, 3'h3, 3'h6});
  endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("bad irq_oe");
  property p_dma_oe; port_dma_request_oe == reg_rdata[3]; endproperty
  a_dma_oe: assert property (p_dma_oe) else $error("bad dreq oe");
  property p_full;
    !(&reg_rdata[1:0]) |-> reg_rdata[1] == (fifo_count == fifo_full_count);
  endproperty
  a_full: assert property (p_full) else $error("bad full flag");
  property p_empty;
    !(&reg_rdata[1:0]) |-> reg_rdata[0] == (fifo_count == 5'h00);
  endproperty
  a_empty: assert property (p_empty) else $error("bad empty flag");
  property p_err;
    fifo_overrun && !reg_write && port_mode == 3'h3 |->
      ##[1:2] &reg_rdata[1:0];
  endproperty
  a_err: assert property (p_err) else $error("no error flags");
  property p_freset;
    fifo_reset == (reg_write && reg_wdata[7:6] == 2'h0);
  endproperty
  a_freset: assert property (p_freset) else $error("bad fifo reset");
  property p_svc;
    $rose(reg_rdata[2]) && !$past(reg_write) |-> ##[0:1] irq_o;
  endproperty
  a_svc: assert property (p_svc) else $error("service without irq");
  property p_fault;
    $fell(fault_b) && port_mode == 3'h3 && !reg_rdata[4] |-> ##[3:5] irq_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault without irq");
endmodule
bind ecr_ctrl ecr_ctrl_chk chk (.core_clk(core_clk), .rst_b(rst_b),
  .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ack_pulse_irq_on(ack_pulse_irq_on), .fifo_count(fifo_count),
  .fifo_overrun(fifo_overrun), .fifo_reset(fifo_reset),
  .port_mode(port_mode), .port_dma_request_oe(port_dma_request_oe),
  .fault_b(fault_b), .irq_o(irq_o), .irq_oe(irq_oe));
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the extended control block
// assumes package, design, checker and dma model compiled first
`timescale 1ns/1ps
`default_nettype none
`define chk(n, e, g) check(n, 8'(e), 8'(g))
module testbench;
  logic core_clk, rst_b, reg_write, ack_pulse_irq_on, ack_pulse_event;
  logic reverse_dir, fifo_overrun, fifo_underrun, fifo_dma_want, fault_b;
  logic fifo_reset, port_dma_acknowledge, term_count, seen;
  logic port_dma_request_o, port_dma_request_oe, irq_o, irq_oe;
  logic [7:0] reg_wdata, reg_rdata;
  logic [4:0] fifo_count;
  logic [2:0] port_mode;
  int n_fail, n_checks, cyc;
  time t_low;
  ecr_ctrl uut (.core_clk(core_clk), .rst_b(rst_b),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ack_pulse_irq_on(ack_pulse_irq_on), .ack_pulse_event(ack_pulse_event),
    .reverse_dir(reverse_dir), .fifo_count(fifo_count),
    .fifo_overrun(fifo_overrun), .fifo_underrun(fifo_underrun),
    .fifo_reset(fifo_reset), .port_mode(port_mode),
    .fifo_dma_want(fifo_dma_want), .term_count(term_count),
    .port_dma_acknowledge(port_dma_acknowledge),
    .port_dma_request_o(port_dma_request_o),
    .port_dma_request_oe(port_dma_request_oe),
    .fault_b(fault_b), .irq_o(irq_o), .irq_oe(irq_oe));
  dma_host_model dma (.core_clk(core_clk), .rst_b(rst_b), .gap(2'h2),
    .port_dma_request_o(port_dma_request_o),
    .port_dma_request_oe(port_dma_request_oe),
    .port_dma_acknowledge(port_dma_acknowledge), .term_count(term_count));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict;
    end
  end
  task automatic check(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    // a strobe dropped in this time step stays low for one edge first
    if (t_low == $time) tick(1);
    reg_wdata = d;
    reg_write = 1'b1;
    tick(1);
    reg_write = 1'b0;
    t_low = $time;
  endtask
  // irq_o stands one cycle, so look at every cycle
  task automatic watch(input int k);
    seen = 1'b0;
    repeat (k) begin
      if (irq_o === 1'b1) seen = 1'b1;
      tick(1);
    end
  endtask
  initial begin
    {rst_b, reg_write, ack_pulse_irq_on, ack_pulse_event} = 4'h0;
    {reverse_dir, fifo_overrun, fifo_underrun, fifo_dma_want} = 4'h0;
    {reg_wdata, fifo_count, fault_b, n_fail, n_checks, cyc} = 0;
    fault_b = 1'b1;
    tick(8);
    rst_b = 1'b1;
    tick(3);
    `chk("reset value", 8'h15, reg_rdata);
    for (int m = 0; m < 8; m++) begin
      wr({3'h0, 3'h5, 2'h3});
      wr({3'(m), 3'h5, 2'h3});
      `chk("mode", m, port_mode);
      `chk("irq enable", m inside {2, 3, 6}, irq_oe);
    end
    ack_pulse_irq_on = 1'b1;
    wr({3'h0, 3'h5, 2'h3});
    `chk("irq enable", 1, irq_oe);
    ack_pulse_event = 1'b1;
    tick(1);
    ack_pulse_event = 1'b0;
    watch(4);
    `chk("ack irq", 1, seen);
    ack_pulse_irq_on = 1'b0;
    wr({3'h3, 3'h5, 2'h3});
    fifo_count = 5'h10;
    watch(3);
    `chk("flags", 2, reg_rdata[1:0]);
    fifo_count = 5'h08;
    watch(3);
    `chk("flags", 0, reg_rdata[1:0]);
    `chk("masked service", 0, seen);
    fault_b = 1'b0;
    watch(8);
    `chk("masked fault", 0, seen);
    wr({3'h3, 3'h1, 2'h3});
    watch(3);
    `chk("fault unmask", 1, seen);
    fault_b = 1'b1;
    tick(6);
    fault_b = 1'b0;
    watch(8);
    `chk("fault edge", 1, seen);
    for (int r = 0; r < 2; r++) begin
      reverse_dir = 1'(r);
      fifo_count = r ? 5'h00 : 5'h10;
      tick(2);
      wr({3'h3, 3'h0, 2'h3});
      fifo_count = 5'h08;
      watch(4);
      `chk("threshold irq", 1, seen);
      `chk("service bit", 1, reg_rdata[2]);
    end
    for (int u = 0; u < 2; u++) begin
      wr({3'h3, 3'h0, 2'h3});
      {fifo_overrun, fifo_underrun} = u ? 2'h1 : 2'h2;
      tick(1);
      {fifo_overrun, fifo_underrun} = 2'h0;
      watch(3);
      `chk("error irq", 1, seen);
      `chk("error flags", 3, reg_rdata[1:0]);
      reg_wdata = {3'h0, 3'h0, 2'h3};
      reg_write = 1'b1;
      #1;
      `chk("fifo reset", 1, fifo_reset);
      tick(1);
      reg_write = 1'b0;
      t_low = $time;
      `chk("error cleared", 0, reg_rdata[1:0]);
    end
    wr({3'h3, 3'h2, 2'h3});
    `chk("dreq enable", 1, port_dma_request_oe);
    fifo_dma_want = 1'b1;
    watch(40);
    `chk("tc irq", 1, seen);
    `chk("tc held", 1, irq_o);
    wr({3'h3, 3'h0, 2'h3});
    tick(2);
    `chk("tc cleared", 0, irq_o);
    `chk("dreq released", 0, port_dma_request_oe);
    give_verdict;
  end
endmodule
`default_nettype wire

// ===== core/ecr_ctrl.sv
// extended control register low bits: fault, dma and service interrupts
// assumes register strobes and fifo status come from core_clk logic
`timescale 1ns/1ps
`default_nettype none
module ecr_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // port control inputs
  input wire logic ack_pulse_irq_on,
  input wire logic ack_pulse_event,
  input wire logic reverse_dir,
  // fifo status from the datapath
  input wire logic [4:0] fifo_count,
  input wire logic fifo_overrun,
  input wire logic fifo_underrun,
  output logic fifo_reset,
  output logic [2:0] port_mode,
  // dma pins
  input wire logic fifo_dma_want,
  input wire logic port_dma_acknowledge,
  input wire logic term_count,
  output logic port_dma_request_o,
  output logic port_dma_request_oe,
  // peripheral fault pin, active low
  input wire logic fault_b,
  // host interrupt pin
  output logic irq_o,
  output logic irq_oe
);
  import ecr_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // a reset that lets go close to a clock edge must not free the
  // flops on different cycles, hence the two-stage release
  logic [1:0] rst_pipe;
  logic rst_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[1];

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  // fault and terminal count are asynchronous to core_clk; only their
  // synchronised edges and the synchronised fault level reach the interrupt logic below
  ecr_event_if ev ();

  ecr_pin_sampler u_sampler (
    .core_clk(core_clk),
    .rst_sync_b(rst_sync_b),
    .fault_b(fault_b),
    .term_count(term_count),
    .ev(ev.detect)
  );

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  port_mode_e mode;
  logic fault_irq_disable;
  logic dma_transfer_on;
  logic service_irq_ctl;
  logic fifo_error;
  logic tc_pending;
  logic err_pending;
  logic irq_latch;

  port_mode_e wr_mode;
  logic wr_fault_dis;
  logic wr_dma_on;
  logic wr_service;
  logic to_compat;
  logic was_compat;
  logic mode_allowed;
  logic fault_reenable;
  logic dma_cleared;

  assign wr_mode = port_mode_e'(reg_wdata[mode_lsb +: 3]);
  assign wr_fault_dis = reg_wdata[fault_irq_disable_bit];
  assign wr_dma_on = reg_wdata[dma_transfer_on_bit];
  assign wr_service = reg_wdata[service_irq_ctl_bit];
  assign to_compat = reg_write &&
    (wr_mode == mode_isa || wr_mode == mode_ps2);
  assign was_compat = (mode == mode_isa || mode == mode_ps2);
  // from a non-compatible mode only a return to 000/001 is accepted
  assign mode_allowed = was_compat || to_compat;
  assign fault_reenable = reg_write && fault_irq_disable && !wr_fault_dis;
  assign dma_cleared = reg_write && !wr_dma_on;

  // ---------------------------------------------------------------
  // service conditions
  // ---------------------------------------------------------------
  logic fifo_err_event;
  logic tc_event;
  logic thresh_hit;
  logic thresh_last;
  logic thresh_event;
  logic service_cond;
  logic fault_event;
  logic next_service;

  assign fifo_err_event = fifo_overrun | fifo_underrun;
  assign tc_event = dma_transfer_on & ev.use_side.tc_rise;
  // edge detection keeps a fifo that sits at the threshold from
  // raising a fresh service event on every cycle
  // forward: free slots reach threshold; reverse: stored bytes reach it
  assign thresh_hit = !dma_transfer_on && (reverse_dir ?
    (fifo_count >= service_threshold) :
    ((fifo_full_count - fifo_count) >= service_threshold));
  assign thresh_event = thresh_hit & ~thresh_last;
  assign service_cond = tc_event | thresh_event | fifo_err_event;

  // fault interrupts only in ecp mode: on a fault edge while not disabled, or on the write that clears the disable bit with the fault active
  assign fault_event = (mode == mode_ecp) && ((!fault_irq_disable &&
    ev.use_side.fault_fall) ||
    (fault_reenable && ev.use_side.fault_active));

  // hardware set wins over a software write in the same cycle
  always_comb begin
    next_service = service_irq_ctl;
    if (reg_write) begin
      next_service = wr_service;
    end
    if (!service_irq_ctl && service_cond) begin
      next_service = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mode <= port_mode_e'(mode_reset);
      fault_irq_disable <= fault_irq_disable_reset;
      dma_transfer_on <= dma_transfer_on_reset;
      service_irq_ctl <= service_irq_ctl_reset;
      thresh_last <= 1'b0;
    end else begin
      if (reg_write && mode_allowed) begin
        mode <= wr_mode;
      end
      if (reg_write) begin
        fault_irq_disable <= wr_fault_dis;
        dma_transfer_on <= wr_dma_on;
      end
      service_irq_ctl <= next_service;
      thresh_last <= thresh_hit;
    end
  end

  // ---------------------------------------------------------------
  // pending interrupt sources
  // ---------------------------------------------------------------
  // these flags hold the host request up after the one-cycle event
  // that raised them; tc_pending also clears on dma off, so software can retire
  // it without losing an error that is still waiting

  // error state: set on overrun/underrun, cleared by return to 000/001
  // it also forces both status flags high, so it is kept even while
  // the service interrupt is masked
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fifo_error <= 1'b0;
    end else if (fifo_err_event) begin
      fifo_error <= 1'b1;
    end else if (to_compat) begin
      fifo_error <= 1'b0;
    end
  end

  // the error interrupt is armed only while the service bit is 0;
  // with the bit at 1 the error is still flagged but the pin is quiet
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      err_pending <= 1'b0;
    end else if (fifo_err_event && !service_irq_ctl) begin
      err_pending <= 1'b1;
    end else if (to_compat) begin
      err_pending <= 1'b0;
    end
  end

  // terminal count interrupt stays pending until dma off or mode 000/001
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tc_pending <= 1'b0;
    end else if (tc_event && !service_irq_ctl) begin
      tc_pending <= 1'b1;
    end else if (dma_cleared || to_compat) begin
      tc_pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // host interrupt
  // ---------------------------------------------------------------
  // ack and fault pulses bypass the service bit; latched so the pin
  // holds the request for a full cycle after a one-cycle event
  logic raise_irq;
  logic next_irq;

  assign raise_irq = fault_event |
    (ack_pulse_irq_on & ack_pulse_event) |
    (!service_irq_ctl & service_cond);
  // with the output disabled the latch still runs, so a request
  // held pending by tc_pending or err_pending in a quiet mode shows once the pin is enabled
  assign next_irq = raise_irq | tc_pending | err_pending;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_latch <= 1'b0;
    end else begin
      irq_latch <= next_irq;
    end
  end

  assign irq_o = irq_latch;
  assign irq_oe = ack_pulse_irq_on || mode == mode_isa_fifo ||
    mode == mode_ecp || mode == mode_test;

  // ---------------------------------------------------------------
  // dma request
  // ---------------------------------------------------------------
  // request drops while the acknowledge is held so one byte moves per
  // grant; the datapath re-asserts its want for the next byte
  logic dreq;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dreq <= 1'b0;
    end else begin
      dreq <= dma_transfer_on && fifo_dma_want &&
        !port_dma_acknowledge && !fifo_error;
    end
  end

  // tri-stated with dma off so the channel can serve another device
  assign port_dma_request_o = dreq;
  assign port_dma_request_oe = dma_transfer_on;

  // ---------------------------------------------------------------
  // fifo status and readback
  // ---------------------------------------------------------------
  // flags follow the count live; an error state overrides both so
  // software sees full and empty set together
  logic queue_full_flag;
  logic queue_empty_flag;

  assign queue_full_flag = fifo_error ||
    fifo_count >= fifo_full_count;
  assign queue_empty_flag = fifo_error ||
    fifo_count == 5'h00;
  assign fifo_reset = to_compat;
  assign port_mode = mode;

  always_comb begin
    reg_rdata = 8'h00;
    reg_rdata[mode_lsb +: 3] = mode;
    reg_rdata[fault_irq_disable_bit] = fault_irq_disable;
    reg_rdata[dma_transfer_on_bit] = dma_transfer_on;
    reg_rdata[service_irq_ctl_bit] = service_irq_ctl;
    reg_rdata[queue_full_flag_bit] = queue_full_flag;
    reg_rdata[queue_empty_flag_bit] = queue_empty_flag;
  end
endmodule
`default_nettype wire

// ===== core/ecr_pin_sampler.sv
// synchronises the fault and terminal count pins and detects their edges
// assumes a synchronous release reset on core_clk
`timescale 1ns/1ps
`default_nettype none
module ecr_pin_sampler (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_sync_b,
  // raw pins
  input wire logic fault_b,
  input wire logic term_count,
  // sampled events
  ecr_event_if.detect ev
);
  logic [1:0] fault_sync;
  logic [1:0] tc_sync;
  logic fault_last;
  logic tc_last;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fault_sync <= 2'h3;
      tc_sync <= 2'h0;
      fault_last <= 1'b1;
      tc_last <= 1'b0;
    end else begin
      fault_sync <= {fault_sync[0], fault_b};
      tc_sync <= {tc_sync[0], term_count};
      fault_last <= fault_sync[1];
      tc_last <= tc_sync[1];
    end
  end

  // one pulse per edge plus the fault level, only second stage is observed
  assign ev.fault_fall = fault_last & ~fault_sync[1];
  assign ev.tc_rise = ~tc_last & tc_sync[1];
  assign ev.fault_active = ~fault_sync[1];
endmodule
`default_nettype wire

// ===== include/ecr_ctrl_pkg.sv
// constants for the parallel port extended control logic
// assumes a single 200 MHz core clock domain
package ecr_ctrl_pkg;
  // mode field encodings
  typedef enum logic [2:0] {
    mode_isa = 3'h0,
    mode_ps2 = 3'h1,
    mode_isa_fifo = 3'h2,
    mode_ecp = 3'h3,
    mode_rsvd4 = 3'h4,
    mode_rsvd5 = 3'h5,
    mode_test = 3'h6,
    mode_config = 3'h7
  } port_mode_e;
  // bit positions inside the extended control register
  localparam int mode_lsb = 5;
  localparam int fault_irq_disable_bit = 4;
  localparam int dma_transfer_on_bit = 3;
  localparam int service_irq_ctl_bit = 2;
  localparam int queue_full_flag_bit = 1;
  localparam int queue_empty_flag_bit = 0;
  // reset values
  localparam logic [2:0] mode_reset = 3'h0;
  localparam logic fault_irq_disable_reset = 1'b1;
  localparam logic dma_transfer_on_reset = 1'b0;
  localparam logic service_irq_ctl_reset = 1'b1;
  // fifo geometry and service threshold
  localparam int fifo_depth = 16;
  localparam logic [4:0] fifo_full_count = 5'h10;
  localparam logic [4:0] service_threshold = 5'h08;
endpackage

// ===== include/ecr_event_if.sv
// carrier for sampled event pulses and the fault level between the top and the edge detector
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
interface ecr_event_if;
  logic fault_fall;
  logic tc_rise;
  logic fault_active;
  modport detect (output fault_fall, output tc_rise, output fault_active);
  modport use_side (input fault_fall, input tc_rise, input fault_active);
endinterface
`default_nettype wire
